// *** src/irq_status_top.sv ***
// top-level interrupt pending, active, missed and bus fault status over APB
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - writing one to a pending-set bit marks that source pending; bit 16 debug.
// - zero bits written to pending-set or pending-clear change nothing.
// - writing one to a pending-clear bit removes that source's pending state.
// - fixed bit map: external lines, converter, radio, security, serial, timers.
// - active register shows which sources are being serviced, same bit map.
// - missed flags live in bits 15 to 2; other bits reserved, read zero.
// - fault bit 3 set on narrow or unaligned peripheral access fault.
// - fault bit 2 set on unprivileged write to protected space.
// - fault bit 1 set on access to unimplemented address space.
// - fault bit 0 set when a fault arrives while another flag is set.
// - missed flag set when an event recurs before its earlier flag cleared.
// - writing one to a missed flag clears it; zero leaves it.
module irq_status_top
	import irq_status_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt sources and core
	input wire logic [NUM_SRC-1:0] src_irq,
	input wire logic [NUM_SRC-1:0] svc_enter,
	input wire logic [NUM_SRC-1:0] svc_exit,
	output logic [NUM_SRC-1:0] pending_out,
	output logic [NUM_SRC-1:0] active_out,
	// second-level events and bus faults
	input wire sl_evt_t sl_evt,
	input wire fault_evt_t fault_evt,
	// interrupt to core
	output logic irq_out
);

	function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
		hit = (addr == off);
	endfunction : hit

	// state
	apb_st_t st_r;
	apb_st_t st_nxt;
	logic [NUM_SRC-1:0] pending_r;
	logic [NUM_SRC-1:0] pending_nxt;
	logic [NUM_SRC-1:0] active_r;
	logic [NUM_SRC-1:0] active_nxt;
	logic [NUM_SRC-1:0] missed_r;
	logic [NUM_SRC-1:0] missed_nxt;
	logic [FAULT_W-1:0] fault_r;
	logic [FAULT_W-1:0] fault_nxt;
	logic [EVT_W-1:0] evt_stat_r;
	logic [EVT_W-1:0] evt_stat_nxt;
	logic [EVT_W-1:0] evt_mask_r;
	logic [EVT_W-1:0] evt_mask_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic irq_r;
	logic irq_nxt;

	// bus decode
	wire logic setup = psel & ~penable & (st_r == ST_IDLE);
	wire logic done = psel & penable & pready_r;
	wire logic sel_missed = hit(paddr, OFF_MISSED);
	wire logic sel_pset = hit(paddr, OFF_PEND_SET);
	wire logic sel_pclr = hit(paddr, OFF_PEND_CLR);
	wire logic sel_active = hit(paddr, OFF_ACTIVE);
	wire logic sel_fault = hit(paddr, OFF_FAULT);
	wire logic sel_estat = hit(paddr, OFF_EVT_STAT);
	wire logic sel_emask = hit(paddr, OFF_EVT_MASK);
	wire logic addr_ok = sel_missed | sel_pset | sel_pclr | sel_active
		| sel_fault | sel_estat | sel_emask;
	wire logic strb_ok = (pstrb == 4'hF);
	wire logic req_err = ~addr_ok | (pwrite & ~strb_ok);
	wire logic wr_ok = done & pwrite & ~pslverr_r;
	wire logic rd_ok = done & ~pwrite & ~pslverr_r;

	// write strobes and the event-status read strobe
	wire logic [NUM_SRC-1:0] pset_bits =
		(wr_ok & sel_pset) ? pwdata[NUM_SRC-1:0] : RST_PEND;
	wire logic [NUM_SRC-1:0] pclr_bits =
		(wr_ok & sel_pclr) ? pwdata[NUM_SRC-1:0] : RST_PEND;
	wire logic [NUM_SRC-1:0] miss_clr_bits =
		(wr_ok & sel_missed) ? pwdata[NUM_SRC-1:0] : RST_MISSED;
	wire logic wr_fault = wr_ok & sel_fault;
	wire logic wr_emask = wr_ok & sel_emask;
	wire logic rd_estat = rd_ok & sel_estat;

	// missed-event detection
	logic [NUM_SRC-1:0] miss_set;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_miss
			if (gi >= MISS_LO && gi <= MISS_HI) begin : g_has
				assign miss_set[gi] = sl_evt.event_pulse[gi]
					& sl_evt.flag_busy[gi];
			end else begin : g_none
				assign miss_set[gi] = 1'b0;
			end
		end
	endgenerate

	// fault capture
	logic [FAULT_W-1:0] flt_set;
	assign flt_set[FLT_WRONG_SIZE] = fault_evt.valid & fault_evt.wrong_size;
	assign flt_set[FLT_PROT] = fault_evt.valid & fault_evt.prot;
	assign flt_set[FLT_UNMAPPED] = fault_evt.valid & fault_evt.unmapped;
	assign flt_set[FLT_OVERFLOW] = fault_evt.valid & (|fault_r);

	// block events
	logic [EVT_W-1:0] evt_set;
	assign evt_set[EVT_MISSED] = |miss_set;
	assign evt_set[EVT_FAULT] = fault_evt.valid;

	// read view of each register
	wire logic [31:0] rd_pend = {{(32-NUM_SRC){1'b0}}, pending_r};
	wire logic [31:0] rd_active = {{(32-NUM_SRC){1'b0}}, active_r};
	wire logic [31:0] rd_missed = {{(32-NUM_SRC){1'b0}}, missed_r};
	wire logic [31:0] rd_fault = {{(32-FAULT_W){1'b0}}, fault_r};
	wire logic [31:0] rd_estat_w = {{(32-EVT_W){1'b0}}, evt_stat_r};
	wire logic [31:0] rd_emask = {{(32-EVT_W){1'b0}}, evt_mask_r};

	always_comb begin
		prdata_nxt = 32'h00000000;
		if (sel_pset | sel_pclr) begin
			prdata_nxt = rd_pend;
		end else if (sel_active) begin
			prdata_nxt = rd_active;
		end else if (sel_missed) begin
			prdata_nxt = rd_missed;
		end else if (sel_fault) begin
			prdata_nxt = rd_fault;
		end else if (sel_estat) begin
			prdata_nxt = rd_estat_w;
		end else if (sel_emask) begin
			prdata_nxt = rd_emask;
		end
	end

	// bus handshake
	always_comb begin
		st_nxt = st_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		case (st_r)
			ST_IDLE: begin
				if (setup) begin
					st_nxt = ST_ACK;
					pready_nxt = 1'b1;
					pslverr_nxt = req_err;
				end
			end
			ST_ACK: begin
				if (done) begin
					st_nxt = ST_IDLE;
				end else begin
					pready_nxt = 1'b1;
					pslverr_nxt = pslverr_r;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// status next values; hardware set wins over software clear
	assign pending_nxt = (pending_r & ~(pclr_bits | svc_enter)) | pset_bits
		| src_irq;
	assign active_nxt = (active_r & ~svc_exit) | svc_enter;
	assign missed_nxt = (missed_r & ~miss_clr_bits) | miss_set;
	assign fault_nxt = (wr_fault ? pwdata[FAULT_W-1:0] : fault_r)
		| flt_set;
	// clear only the bits the read actually returned
	assign evt_stat_nxt = (evt_stat_r & ~(rd_estat ? prdata_r[EVT_W-1:0] : RST_EVT))
		| evt_set;
	assign evt_mask_nxt = wr_emask ? pwdata[EVT_W-1:0] : evt_mask_r;
	assign irq_nxt = |(evt_stat_r & evt_mask_r);

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= ST_IDLE;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			st_r <= st_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= setup ? prdata_nxt : prdata_r;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pending_r <= RST_PEND;
			active_r <= RST_ACTIVE;
			missed_r <= RST_MISSED;
			fault_r <= RST_FAULT;
		end else begin
			pending_r <= pending_nxt;
			active_r <= active_nxt;
			missed_r <= missed_nxt;
			fault_r <= fault_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			evt_stat_r <= RST_EVT;
			evt_mask_r <= RST_EVT;
			irq_r <= 1'b0;
		end else begin
			evt_stat_r <= evt_stat_nxt;
			evt_mask_r <= evt_mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// outputs straight from flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pending_out = pending_r;
	assign active_out = active_r;
	assign irq_out = irq_r;

endmodule : irq_status_top

// *** include/irq_status_pkg.sv ***
// constants and types for the top-level interrupt status block
package irq_status_pkg;
	// register byte addresses
	localparam logic [31:0] OFF_MISSED = 32'h4000A820;
	localparam logic [31:0] OFF_PEND_SET = 32'hE000E200;
	localparam logic [31:0] OFF_PEND_CLR = 32'hE000E280;
	localparam logic [31:0] OFF_ACTIVE = 32'hE000E300;
	localparam logic [31:0] OFF_FAULT = 32'hE000ED3C;
	localparam logic [31:0] OFF_EVT_STAT = 32'hE000EF00;
	localparam logic [31:0] OFF_EVT_MASK = 32'hE000EF04;

	// source bit positions
	localparam int NUM_SRC = 17;
	localparam int SRC_DEBUG = 16;
	localparam int SRC_EXT_D = 15;
	localparam int SRC_EXT_C = 14;
	localparam int SRC_EXT_B = 13;
	localparam int SRC_EXT_A = 12;
	localparam int SRC_ADC = 11;
	localparam int SRC_RADIO_RX = 10;
	localparam int SRC_RADIO_TX = 9;
	localparam int SRC_RADIO_TMR = 8;
	localparam int SRC_SECURITY = 7;
	localparam int SRC_SERIAL_TWO = 6;
	localparam int SRC_SERIAL_ONE = 5;
	localparam int SRC_SLEEP_TMR = 4;
	localparam int SRC_BASEBAND = 3;
	localparam int SRC_MGMT = 2;
	localparam int SRC_TIMER_TWO = 1;
	localparam int SRC_TIMER_ONE = 0;

	// missed flags exist for these sources only
	localparam int MISS_LO = 2;
	localparam int MISS_HI = 15;

	// fault status fields
	localparam int FAULT_W = 4;
	localparam int FLT_WRONG_SIZE = 3;
	localparam int FLT_PROT = 2;
	localparam int FLT_UNMAPPED = 1;
	localparam int FLT_OVERFLOW = 0;

	// event status / mask fields
	localparam int EVT_W = 2;
	localparam int EVT_MISSED = 0;
	localparam int EVT_FAULT = 1;

	// reset values
	localparam logic [NUM_SRC-1:0] RST_PEND = 17'h00000;
	localparam logic [NUM_SRC-1:0] RST_ACTIVE = 17'h00000;
	localparam logic [NUM_SRC-1:0] RST_MISSED = 17'h00000;
	localparam logic [FAULT_W-1:0] RST_FAULT = 4'h0;
	localparam logic [EVT_W-1:0] RST_EVT = 2'h0;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_ACK = 1'b1
	} apb_st_t;

	// one bus fault report from the bus fabric
	typedef struct packed {
		logic valid;
		logic wrong_size;
		logic prot;
		logic unmapped;
	} fault_evt_t;

	// second-level event report per source
	typedef struct packed {
		logic [NUM_SRC-1:0] event_pulse;
		logic [NUM_SRC-1:0] flag_busy;
	} sl_evt_t;
endpackage : irq_status_pkg

// *** tb/irq_status_chk.sv ***
// port checks for the interrupt status block
`timescale 1ns/1ps
module irq_status_chk
	import irq_status_pkg::*;
(
	// apb
	input wire logic clk, srst, psel, penable, pwrite, pready,
	input wire logic [31:0] paddr, pwdata, prdata,
	// sources and core
	input wire logic [NUM_SRC-1:0] src_irq, svc_enter, svc_exit, pending_out, active_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire quiet = src_irq == '0 && svc_enter == '0;
	wire wr = psel && penable && pready && pwrite && quiet;
	wire wset = wr && paddr == OFF_PEND_SET;
	wire wclr = wr && paddr == OFF_PEND_CLR;
	wire rd = psel && !penable && !pwrite;
	property p_ans; psel && !penable |=> pready && penable; endproperty
	a_ans: assert property (p_ans) else $error("no answer after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_set; wset |=> (pending_out & $past(pwdata[16:0])) == $past(pwdata[16:0]);
	endproperty
	a_set: assert property (p_set) else $error("pend set lost");
	property p_clr; wclr |=> (pending_out & $past(pwdata[16:0])) == '0; endproperty
	a_clr: assert property (p_clr) else $error("pend clear lost");
	property p_keep;
		wset || wclr |=> ((pending_out ^ $past(pending_out)) & ~$past(pwdata[16:0])) == '0;
	endproperty
	a_keep: assert property (p_keep) else $error("zero bit changed");
	property p_act;
		svc_enter != '0 && svc_exit == '0 |=> (active_out & $past(svc_enter)) == $past(svc_enter);
	endproperty
	a_act: assert property (p_act) else $error("active not set");
	property p_rdact;
		rd && paddr == OFF_ACTIVE |=> prdata == {15'h0, $past(active_out)};
	endproperty
	a_rdact: assert property (p_rdact) else $error("active read wrong");
	property p_rdmiss;
		rd && paddr == OFF_MISSED |=> prdata[31:16] == 16'h0 && prdata[1:0] == 2'h0;
	endproperty
	a_rdmiss: assert property (p_rdmiss) else $error("reserved bits set");
endmodule : irq_status_chk
bind irq_status_top irq_status_chk u_chk (.*);

// *** tb/irq_far_model.sv ***
// far side: sources, core service pulses, second-level events, bus faults
`timescale 1ns/1ps
module irq_far_model
	import irq_status_pkg::*;
(
	input wire logic clk,
	// one-cycle pulses
	output logic [NUM_SRC-1:0] src_irq, svc_enter, svc_exit,
	output sl_evt_t sl_evt,
	output fault_evt_t fault_evt
);
	initial {src_irq, svc_enter, svc_exit, sl_evt, fault_evt} = '0;
	task automatic fire(input logic [16:0] s, en, ex, input logic [33:0] e,
		input logic [3:0] f);
		@(posedge clk);
		src_irq <= s;
		svc_enter <= en;
		svc_exit <= ex;
		sl_evt <= e;
		fault_evt <= f;
		@(posedge clk);
		{src_irq, svc_enter, svc_exit, sl_evt, fault_evt} <= '0;
	endtask : fire
endmodule : irq_far_model

// *** tb/tb_top.sv ***
// self-checking bench for the interrupt status block
`timescale 1ns/1ps
module tb_top;
	import irq_status_pkg::*;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_out;
	logic [31:0] paddr = 0, pwdata = 0, prdata, q, w, c;
	logic [NUM_SRC-1:0] src_irq, svc_enter, svc_exit, pending_out, active_out;
	sl_evt_t sl_evt;
	fault_evt_t fault_evt;
	int bad_count = 0, checks = 0, seed = 32'hEAF4, pend = 0, act = 0, miss = 0, flt = 0;
	initial forever #2 clk = ~clk;
	irq_status_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_irq(src_irq), .svc_enter(svc_enter),
		.svc_exit(svc_exit), .pending_out(pending_out), .active_out(active_out),
		.sl_evt(sl_evt), .fault_evt(fault_evt), .irq_out(irq_out));
	irq_far_model u_far (.clk(clk), .src_irq(src_irq), .svc_enter(svc_enter),
		.svc_exit(svc_exit), .sl_evt(sl_evt), .fault_evt(fault_evt));
	task automatic cmp(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task automatic apb(input logic wr, input logic [31:0] a, d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		c = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [31:0] a, e);
		apb(1'b0, a, 32'h0);
		cmp("rdata", e, q);
	endtask : rd
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		#40000;
		bad_count++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_PEND_SET, 0);
		rd(OFF_FAULT, 0);
		rd(OFF_MISSED, 0);
		repeat (6) begin
			w = $random(seed) & 32'h1FFFF;
			apb(1'b1, OFF_PEND_SET, w);
			pend |= w;
			w = $random(seed) & 32'h1FFFF;
			u_far.fire(w[16:0], 0, 0, 0, 0);
			pend |= w;
			rd(OFF_PEND_CLR, pend);
			w = $random(seed) & 32'h1FFFF;
			apb(1'b1, OFF_PEND_CLR, w);
			pend &= ~w;
			#1 cmp("pending", pend, {15'h0, pending_out});
		end
		w = $random(seed) & 32'h1FFFF;
		u_far.fire(0, w[16:0], 0, 0, 0);
		act = w;
		apb(1'b1, OFF_ACTIVE, 32'h1FFFF);
		rd(OFF_ACTIVE, act);
		u_far.fire(0, 0, w[16:0] & 17'h0F0F0, 0, 0);
		act &= ~(w & 32'hF0F0);
		rd(OFF_ACTIVE, act);
		w = $random(seed);
		c = $random(seed);
		u_far.fire(0, 0, 0, {w[16:0], c[16:0]}, 0);
		miss = w & c & 32'hFFFC;
		rd(OFF_MISSED, miss);
		w = $random(seed) & 32'hFFFF;
		apb(1'b1, OFF_MISSED, w);
		rd(OFF_MISSED, miss & ~w);
		for (int i = 0; i < 3; i++) begin
			u_far.fire(0, 0, 0, 0, 4'h8 | (4'h1 << i));
			flt = flt | (flt != 0) | (2 << i);
			rd(OFF_FAULT, flt);
		end
		apb(1'b1, OFF_FAULT, 32'h0);
		rd(OFF_FAULT, 0);
		rd(32'hE000E304, 0);
		cmp("slverr", 1, c);
		cmp("irq", 0, {31'h0, irq_out});
		apb(1'b1, OFF_EVT_MASK, 32'h2);
		repeat (3) @(posedge clk);
		cmp("irq", 1, {31'h0, irq_out});
		rd(OFF_EVT_STAT, {30'h0, 1'b1, miss != 0});
		repeat (3) @(posedge clk);
		cmp("irq", 0, {31'h0, irq_out});
		stop_test;
	end
endmodule : tb_top
